// [inc/msr_pkg.sv]
// Package with constants and types of the motor speed ramp and bump block.
package msr_pkg;

    // ****************************************************************
    // Clock and timing.
    // ****************************************************************
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int BASE_TICK_US = 1000;
    localparam int BASE_TICK_CYC = (BASE_TICK_US * CLK_FREQ_KHZ) / 1000;

    // ****************************************************************
    // Setting indices on the programming port.
    // ****************************************************************
    localparam logic [7:0] IDX_START_VOLTAGE = 8'h02;
    localparam logic [7:0] IDX_ACCEL_RATE = 8'h03;
    localparam logic [7:0] IDX_DECEL_RATE = 8'h04;
    localparam logic [7:0] IDX_MAX_VOLTAGE = 8'h05;
    localparam logic [7:0] IDX_MID_VOLTAGE = 8'h06;
    localparam logic [7:0] IDX_BUMP_AMOUNT = 8'h38;
    localparam logic [7:0] IDX_BUMP_DURATION = 8'h39;

    // ****************************************************************
    // Reset values and limits.
    // ****************************************************************
    localparam logic [7:0] RST_START_VOLTAGE = 8'h09;
    localparam logic [7:0] RST_ACCEL_RATE = 8'h02;
    localparam logic [7:0] RST_DECEL_RATE = 8'h02;
    localparam logic [7:0] RST_MAX_VOLTAGE = 8'hFF;
    localparam logic [7:0] RST_MID_VOLTAGE = 8'h80;
    localparam logic [7:0] RST_BUMP_AMOUNT = 8'h00;
    localparam logic [7:0] RST_BUMP_DURATION = 8'h00;
    localparam logic [7:0] MIN_RATE = 8'h01;
    localparam logic [7:0] MAX_BUMP_DURATION = 8'h7F;
    localparam logic [7:0] NEAR_STOP_LEVEL = 8'h10;
    localparam logic [7:0] FULL_DRIVE = 8'hFF;

    // ****************************************************************
    // Speed steps.
    // ****************************************************************
    localparam logic [4:0] STEP_LOW_FIRST = 5'h01;
    localparam logic [4:0] STEP_MID = 5'h0E;
    localparam logic [4:0] STEP_TOP = 5'h1C;
    localparam int LOW_SPAN = 13;
    localparam int HIGH_SPAN = 14;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] start_voltage_setting;
        logic [7:0] accel_rate_setting;
        logic [7:0] decel_rate_setting;
        logic [7:0] max_voltage_setting;
        logic [7:0] mid_voltage_setting;
        logic [7:0] bump_amount_setting;
        logic [7:0] bump_duration_setting;
    } msr_cfg_s;

    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] data;
    } msr_cv_s;

    typedef enum logic [1:0] {
        MSR_IDLE = 2'b00,
        MSR_RUN = 2'b01,
        MSR_REVERSE = 2'b10
    } msr_state_e;

endpackage

// [rtl/msr_core.sv]
// Motor speed ramp, start bump and reversal interlock of a locomotive decoder.
//
// Overview of operation
// (R1) Bump amount setting is 8 bits, range 0 to 255, reset 0.
// (R2) Bump amount zero adds no extra voltage at any step.
// (R3) Bump amount scales against full drive; 128 adds half of full drive.
// (R4) Once the locomotive moves, bump stops and speed curve alone drives.
// (R5) Bump duration setting range 0 to 127, reset 0, sets bump length.
// (R6) Bump duration zero disables bumping whatever the amount holds.
// (R7) Transition from bump drive to plain curve drive happens automatically.
// (R8) Acceleration rate 1 to 255, reset 2, smaller means faster rise.
// (R9) Deceleration rate 1 to 255, reset 2, smaller means faster fall.
// (R10) Both rates act identically forward and reverse.
// (R11) Writing zero to either rate stores one instead.
// (R12) Direction change while moving ramps to zero, switches, ramps back up.
// (R13) Steps 1-14 use start and mid settings; steps 15-28 mid and max.
// (R14) Ramp moves one increment each time rate counter expires on base tick.
// (R15) Bump duration counts base ticks; bump starts on step change near standstill.
`timescale 1ns/1ps
module msr_core #(
    parameter int TICK_CYC = msr_pkg::BASE_TICK_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] speed_step_i,
    input wire logic dir_i,
    input wire logic cv_wr_i,
    input wire logic [7:0] cv_idx_i,
    input wire logic [7:0] cv_data_i,
    output logic [7:0] cv_rdata_o,
    output logic [7:0] motor_drive_o,
    output logic motor_dir_o,
    output logic bump_active_o
);

    // ****************************************************************
    // Settings.
    // ****************************************************************
    msr_pkg::msr_cfg_s cfg_q;
    msr_pkg::msr_cfg_s cfg_d;
    msr_pkg::msr_cv_s cv;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    assign cv.wr = cv_wr_i;
    assign cv.idx = cv_idx_i;
    assign cv.data = cv_data_i;

    always_comb begin
        cfg_d = cfg_q;
        if (cv.wr) begin
            case (cv.idx)
                msr_pkg::IDX_START_VOLTAGE: cfg_d.start_voltage_setting = cv.data;
                msr_pkg::IDX_MAX_VOLTAGE: cfg_d.max_voltage_setting = cv.data;
                msr_pkg::IDX_MID_VOLTAGE: cfg_d.mid_voltage_setting = cv.data;
                msr_pkg::IDX_ACCEL_RATE: begin
                    // A zero rate is replaced so speed can never jump at once. [R11] [R8]
                    cfg_d.accel_rate_setting = (cv.data == 8'h00) ? msr_pkg::MIN_RATE : cv.data;
                end
                msr_pkg::IDX_DECEL_RATE: begin
                    cfg_d.decel_rate_setting = (cv.data == 8'h00) ? msr_pkg::MIN_RATE : cv.data; // [R11] [R9]
                end
                msr_pkg::IDX_BUMP_AMOUNT: cfg_d.bump_amount_setting = cv.data; // [R1]
                msr_pkg::IDX_BUMP_DURATION: begin
                    // Values above the range are held at the top of the range. [R5]
                    cfg_d.bump_duration_setting = (cv.data > msr_pkg::MAX_BUMP_DURATION) ?
                        msr_pkg::MAX_BUMP_DURATION : cv.data;
                end
                default: cfg_d = cfg_q;
            endcase
        end
    end

    always_comb begin
        case (cv.idx)
            msr_pkg::IDX_START_VOLTAGE: rdata_d = cfg_q.start_voltage_setting;
            msr_pkg::IDX_ACCEL_RATE: rdata_d = cfg_q.accel_rate_setting;
            msr_pkg::IDX_DECEL_RATE: rdata_d = cfg_q.decel_rate_setting;
            msr_pkg::IDX_MAX_VOLTAGE: rdata_d = cfg_q.max_voltage_setting;
            msr_pkg::IDX_MID_VOLTAGE: rdata_d = cfg_q.mid_voltage_setting;
            msr_pkg::IDX_BUMP_AMOUNT: rdata_d = cfg_q.bump_amount_setting;
            msr_pkg::IDX_BUMP_DURATION: rdata_d = cfg_q.bump_duration_setting;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q.start_voltage_setting <= msr_pkg::RST_START_VOLTAGE;
            cfg_q.accel_rate_setting <= msr_pkg::RST_ACCEL_RATE;
            cfg_q.decel_rate_setting <= msr_pkg::RST_DECEL_RATE;
            cfg_q.max_voltage_setting <= msr_pkg::RST_MAX_VOLTAGE;
            cfg_q.mid_voltage_setting <= msr_pkg::RST_MID_VOLTAGE;
            cfg_q.bump_amount_setting <= msr_pkg::RST_BUMP_AMOUNT;
            cfg_q.bump_duration_setting <= msr_pkg::RST_BUMP_DURATION;
            rdata_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign cv_rdata_o = rdata_q;

    // ****************************************************************
    // Speed curve.
    // ****************************************************************
    logic [7:0] curve_level;

    always_comb begin
        int lo;
        int hi;
        int res;
        lo = 0;
        hi = 0;
        res = 0;
        if (speed_step_i >= msr_pkg::STEP_LOW_FIRST && speed_step_i <= msr_pkg::STEP_MID) begin
            lo = int'(cfg_q.start_voltage_setting);
            hi = int'(cfg_q.mid_voltage_setting);
            res = lo + ((hi - lo) * int'(speed_step_i - msr_pkg::STEP_LOW_FIRST)) / msr_pkg::LOW_SPAN; // [R13]
        end else if (speed_step_i > msr_pkg::STEP_MID) begin
            lo = int'(cfg_q.mid_voltage_setting);
            hi = int'(cfg_q.max_voltage_setting);
            res = lo + ((hi - lo) * int'(speed_step_i - msr_pkg::STEP_MID)) / msr_pkg::HIGH_SPAN; // [R13]
            if (speed_step_i >= msr_pkg::STEP_TOP) begin
                res = hi;
            end
        end
        curve_level = res[7:0];
    end

    // ****************************************************************
    // Ramp, reversal and bump.
    // ****************************************************************
    msr_pkg::msr_state_e state_q;
    msr_pkg::msr_state_e state_d;
    logic [31:0] tick_cnt_q;
    logic [31:0] tick_cnt_d;
    logic tick;
    logic [7:0] rate_cnt_q;
    logic [7:0] rate_cnt_d;
    logic [7:0] level_q;
    logic [7:0] level_d;
    logic dir_q;
    logic dir_d;
    logic [4:0] step_q;
    logic [4:0] step_d;
    logic [7:0] bump_cnt_q;
    logic [7:0] bump_cnt_d;
    logic [7:0] target;
    logic [7:0] rate;
    logic [8:0] bump_sum;
    logic bump_on;

    assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

    always_comb begin
        tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
        state_d = state_q;
        dir_d = dir_q;
        level_d = level_q;
        rate_cnt_d = rate_cnt_q;
        step_d = speed_step_i;
        bump_cnt_d = bump_cnt_q;
        // A pending reversal forces the target to zero first. [R12]
        target = (dir_i != dir_q) ? 8'h00 : curve_level;
        // The same two rates serve both directions. [R10] [R8] [R9]
        rate = (target > level_q) ? cfg_q.accel_rate_setting : cfg_q.decel_rate_setting;
        case (state_q)
            msr_pkg::MSR_IDLE: begin
                if (dir_i != dir_q && level_q == 8'h00) begin
                    // Only a locomotive at standstill may flip direction at once. [R12]
                    dir_d = dir_i;
                end else if (target != level_q) begin
                    // A reversal at steady speed enters the ramp-down first. [R12]
                    state_d = (dir_i != dir_q) ? msr_pkg::MSR_REVERSE : msr_pkg::MSR_RUN;
                    rate_cnt_d = rate;
                end
            end
            msr_pkg::MSR_RUN, msr_pkg::MSR_REVERSE: begin
                if (dir_i != dir_q) begin
                    state_d = msr_pkg::MSR_REVERSE;
                end
                if (tick) begin
                    if (rate_cnt_q <= msr_pkg::MIN_RATE) begin
                        rate_cnt_d = rate; // [R14]
                        if (target > level_q) begin
                            level_d = level_q + 8'h01; // [R14]
                        end else if (target < level_q) begin
                            level_d = level_q - 8'h01; // [R14]
                        end
                    end else begin
                        rate_cnt_d = rate_cnt_q - 8'h01;
                    end
                end
                if (level_q == 8'h00 && dir_i != dir_q) begin
                    // Direction flips only at standstill, then the ramp climbs again. [R12]
                    dir_d = dir_i;
                    state_d = msr_pkg::MSR_RUN;
                end else if (level_q == target && dir_i == dir_q) begin
                    state_d = msr_pkg::MSR_IDLE;
                end
            end
            default: state_d = msr_pkg::MSR_IDLE;
        endcase
        if (level_q > msr_pkg::NEAR_STOP_LEVEL || cfg_q.bump_duration_setting == 8'h00) begin
            // Moving, or duration zero: bump drops away on its own. [R4] [R6] [R7]
            bump_cnt_d = 8'h00;
        end else if (speed_step_i != step_q && speed_step_i != 5'h00) begin
            bump_cnt_d = cfg_q.bump_duration_setting; // [R15]
        end else if (tick && bump_cnt_q != 8'h00) begin
            bump_cnt_d = bump_cnt_q - 8'h01; // [R15]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= msr_pkg::MSR_IDLE;
            tick_cnt_q <= 32'h0;
            rate_cnt_q <= 8'h00;
            level_q <= 8'h00;
            dir_q <= 1'b0;
            step_q <= 5'h00;
            bump_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            tick_cnt_q <= tick_cnt_d;
            rate_cnt_q <= rate_cnt_d;
            level_q <= level_d;
            dir_q <= dir_d;
            step_q <= step_d;
            bump_cnt_q <= bump_cnt_d;
        end
    end

    // ****************************************************************
    // Motor drive.
    // ****************************************************************
    logic [7:0] drive_q;
    logic [7:0] drive_d;
    logic bump_q;

    assign bump_on = (bump_cnt_q != 8'h00) && (cfg_q.bump_amount_setting != 8'h00); // [R2]
    assign bump_sum = {1'b0, level_q} + {1'b0, cfg_q.bump_amount_setting};

    always_comb begin
        drive_d = level_q;
        if (bump_on) begin
            // The amount adds straight onto the ramp level, capped at full drive. [R3]
            drive_d = bump_sum[8] ? msr_pkg::FULL_DRIVE : bump_sum[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_q <= 8'h00;
            bump_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            bump_q <= bump_on;
        end
    end

    assign motor_drive_o = drive_q;
    assign motor_dir_o = dir_q;
    assign bump_active_o = bump_q;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    AST_RATE_NEVER_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R11]
        cfg_q.accel_rate_setting != 8'h00 && cfg_q.decel_rate_setting != 8'h00)
        else $error("Rate setting holds zero.");

    AST_ZERO_WRITE_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R11]
        (cv_wr_i && cv_idx_i == msr_pkg::IDX_ACCEL_RATE && cv_data_i == 8'h00)
        |=> cfg_q.accel_rate_setting == msr_pkg::MIN_RATE)
        else $error("Zero accel write not stored as one.");

    AST_NO_BUMP_AMOUNT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R2]
        cfg_q.bump_amount_setting == 8'h00 |=> motor_drive_o == $past(level_q))
        else $error("Drive differs from ramp level with zero bump amount.");

    AST_NO_BUMP_DURATION: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R6]
        cfg_q.bump_duration_setting == 8'h00 |=> !bump_on)
        else $error("Bump active with zero duration.");

    AST_BUMP_ENDS_MOVING: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R4]
        level_q > msr_pkg::NEAR_STOP_LEVEL |=> bump_cnt_q == 8'h00)
        else $error("Bump kept while moving.");

    AST_BUMP_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R3]
        (bump_on && level_q == 8'h00) |=> motor_drive_o == $past(cfg_q.bump_amount_setting))
        else $error("Bump level wrong at standstill.");

    AST_DIR_AT_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R12]
        $changed(dir_q) |-> $past(level_q) == 8'h00)
        else $error("Direction changed while moving.");

    AST_REVERSE_TARGET: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R12]
        (dir_i != dir_q && level_q != 8'h00 && tick && rate_cnt_q <= msr_pkg::MIN_RATE
         && state_q != msr_pkg::MSR_IDLE) |=> level_q == $past(level_q) - 8'h01)
        else $error("Reversal did not ramp down.");

    AST_RAMP_ON_TICK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R14]
        $changed(level_q) |-> $past(tick) && ($past(level_q) - level_q == 8'h01
                                            || level_q - $past(level_q) == 8'h01))
        else $error("Ramp moved off tick or by more than one.");

    AST_CURVE_ENDS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R13]
        (speed_step_i == msr_pkg::STEP_MID |-> curve_level == cfg_q.mid_voltage_setting)
        and (speed_step_i == msr_pkg::STEP_TOP |-> curve_level == cfg_q.max_voltage_setting)
        and (speed_step_i == msr_pkg::STEP_LOW_FIRST
             |-> curve_level == cfg_q.start_voltage_setting))
        else $error("Speed curve end points wrong.");

endmodule

// [tb/msr_throttle.sv]
// Behavioural remote throttle that presents speed step and direction.
`timescale 1ns/1ps
module msr_throttle (
    input wire logic sys_clk_i,
    output logic [4:0] speed_step_o,
    output logic dir_o
);
    // ****************************************************************
    // Throttle command.
    // ****************************************************************
    initial begin
        speed_step_o = 5'h00;
        dir_o = 1'b0;
    end

    // Changes the command just after a rising edge and holds it as a level.
    task automatic set_throttle(input logic [4:0] step, input logic dir);
        @(posedge sys_clk_i);
        #1;
        speed_step_o = step;
        dir_o = dir;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking testbench of the motor speed ramp and bump block.
`timescale 1ns/1ps
module testbench;
    localparam int TICK = 4;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cv_wr_i = 1'b0;
    logic [7:0] cv_idx_i = 8'h00;
    logic [7:0] cv_data_i = 8'h00;
    logic [4:0] speed_step;
    logic dir;
    logic [7:0] cv_rdata_o;
    logic [7:0] motor_drive_o;
    logic motor_dir_o;
    logic bump_active_o;
    logic [7:0] v;
    int failures = 0;
    int total_checks = 0;
    int n;
    int r;
    logic [7:0] idx_tab [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h38, 8'h39};
    logic [7:0] rst_tab [7] = '{8'h09, 8'h02, 8'h02, 8'hFF, 8'h80, 8'h00, 8'h00};
    int step_tab [5] = '{1, 7, 14, 21, 28};

    always #50 sys_clk_i = ~sys_clk_i;

    msr_throttle msr_throttle_inst (
        .sys_clk_i(sys_clk_i),
        .speed_step_o(speed_step),
        .dir_o(dir)
    );

    msr_core #(.TICK_CYC(TICK)) msr_core_inst (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .speed_step_i(speed_step),
        .dir_i(dir),
        .cv_wr_i(cv_wr_i),
        .cv_idx_i(cv_idx_i),
        .cv_data_i(cv_data_i),
        .cv_rdata_o(cv_rdata_o),
        .motor_drive_o(motor_drive_o),
        .motor_dir_o(motor_dir_o),
        .bump_active_o(bump_active_o)
    );

    // ****************************************************************
    // Compare, access and reporting tasks.
    // ****************************************************************
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_span(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic cv_write(input logic [7:0] idx, input logic [7:0] data);
        @(posedge sys_clk_i);
        #1;
        cv_wr_i = 1'b1;
        cv_idx_i = idx;
        cv_data_i = data;
        @(posedge sys_clk_i);
        #1;
        cv_wr_i = 1'b0;
    endtask

    task automatic cv_read(input logic [7:0] idx, output logic [7:0] val);
        @(posedge sys_clk_i);
        #1;
        cv_idx_i = idx;
        @(posedge sys_clk_i);
        #1;
        val = cv_rdata_o;
    endtask

    task automatic wait_drive(input logic [7:0] lvl, input int lim, output int cyc);
        cyc = 0;
        while (motor_drive_o !== lvl && cyc < lim) begin
            @(posedge sys_clk_i);
            #1;
            cyc++;
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask

    function automatic logic [7:0] curve(input int s);
        if (s <= 14) return 8'(9 + (119 * (s - 1)) / 13);
        return 8'(128 + (127 * (s - 14)) / 14);
    endfunction

    task automatic end_test(input string name);
        $display("TEST %s done, mismatches so far %0d", name, failures);
    endtask

    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            cv_read(idx_tab[i], v);
            check_byte("setting reset", rst_tab[i], v);
        end
        cv_read(8'h07, v);
        check_byte("unknown index", 8'h00, v);
        cv_write(8'h03, 8'h00);
        cv_write(8'h04, 8'h00);
        cv_write(8'h39, 8'hC8);
        cv_write(8'h38, 8'hFF);
        cv_read(8'h03, v);
        check_byte("accel zero", 8'h01, v);
        cv_read(8'h04, v);
        check_byte("decel zero", 8'h01, v);
        cv_read(8'h39, v);
        check_byte("duration clamp", 8'h7F, v);
        cv_read(8'h38, v);
        check_byte("amount full", 8'hFF, v);
        cv_write(8'h39, 8'h00);
        cv_write(8'h38, 8'h00);
        end_test("settings");
        for (int k = 0; k < 4; k++) begin
            r = (k < 2) ? 1 : 3;
            cv_write(8'h03, 8'(r));
            cv_write(8'h04, 8'(r));
            msr_throttle_inst.set_throttle(5'h01, k[0]);
            wait_drive(8'h09, 400, n);
            check_span("rise time", (9 * r - 3) * TICK, (9 * r + 1) * TICK + 4, n);
            check_flag("direction", k[0], motor_dir_o);
            msr_throttle_inst.set_throttle(5'h00, k[0]);
            wait_drive(8'h00, 400, n);
            check_span("fall time", (9 * r - 3) * TICK, (9 * r + 1) * TICK + 4, n);
        end
        end_test("rates");
        cv_write(8'h03, 8'h01);
        cv_write(8'h04, 8'h01);
        for (int i = 0; i < 5; i++) begin
            msr_throttle_inst.set_throttle(5'(step_tab[i]), 1'b0);
            wait_drive(curve(step_tab[i]), 1200, n);
            check_byte("curve level", curve(step_tab[i]), motor_drive_o);
        end
        end_test("curve");
        msr_throttle_inst.set_throttle(5'h1C, 1'b1);
        n = 0;
        while (motor_dir_o !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check_flag("direction flip", 1'b1, motor_dir_o);
        check_byte("level at flip", 8'h00, motor_drive_o);
        check_span("slowdown time", 250 * TICK, 262 * TICK, n);
        wait_drive(8'hFF, 1200, n);
        check_byte("speed after reversal", 8'hFF, motor_drive_o);
        end_test("reversal");
        msr_throttle_inst.set_throttle(5'h00, 1'b1);
        wait_drive(8'h00, 1200, n);
        cv_write(8'h03, 8'hFF);
        cv_write(8'h38, 8'h80);
        msr_throttle_inst.set_throttle(5'h01, 1'b1);
        cycles(10);
        check_flag("bump zero duration", 1'b0, bump_active_o);
        check_byte("drive zero duration", 8'h00, motor_drive_o);
        msr_throttle_inst.set_throttle(5'h00, 1'b1);
        cv_write(8'h38, 8'h00);
        cv_write(8'h39, 8'h32);
        msr_throttle_inst.set_throttle(5'h01, 1'b1);
        cycles(10);
        check_byte("drive zero amount", 8'h00, motor_drive_o);
        msr_throttle_inst.set_throttle(5'h00, 1'b1);
        cv_write(8'h39, 8'h00);
        cv_write(8'h38, 8'h80);
        cv_write(8'h39, 8'h05);
        check_flag("bump idle before start", 1'b0, bump_active_o);
        msr_throttle_inst.set_throttle(5'h01, 1'b1);
        cycles(3);
        check_flag("bump start", 1'b1, bump_active_o);
        check_byte("bump half drive", 8'h80, motor_drive_o);
        cycles(5 * TICK + 6);
        check_flag("bump expired", 1'b0, bump_active_o);
        check_byte("drive after bump", 8'h00, motor_drive_o);
        msr_throttle_inst.set_throttle(5'h00, 1'b1);
        cv_write(8'h03, 8'h01);
        cv_write(8'h38, 8'h0F);
        cv_write(8'h39, 8'h7F);
        msr_throttle_inst.set_throttle(5'h1C, 1'b1);
        cycles(3);
        check_flag("bump on start", 1'b1, bump_active_o);
        wait_drive(8'h64, 600, n);
        check_byte("plain curve drive", 8'h64, motor_drive_o);
        check_flag("bump gone when moving", 1'b0, bump_active_o);
        end_test("bump");
        final_report;
    end

    initial begin
        #3000000;
        failures++;
        $display("BAD watchdog expected finish seen timeout");
        final_report;
    end
endmodule
